// file: rtl/radio_host_link_defines.svh
`ifndef RADIO_HOST_LINK_DEFINES_SVH
`define RADIO_HOST_LINK_DEFINES_SVH

// ----------------------------------------
// Serial port timing
// ----------------------------------------
`define SCLK_HALF_CYC 4'h4
`define SEL_GUARD_CYC 4'h4
`define SERIAL_BITS 4'h8

// ----------------------------------------
// Pin bank
// ----------------------------------------
`define PIN_COUNT 16
`define RADIO_IRQ_PIN 13
`define SENSE_RESET 1'b1
`define LOC_FIRST 1'b0

`endif

// file: rtl/radio_host_link_pkg.sv
package radio_host_link_pkg;

    // ----------------------------------------
    // Reflex conditioning modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        COND_LEVEL = 2'b00,
        COND_RISE = 2'b01,
        COND_FALL = 2'b10,
        COND_BOTH = 2'b11
    } reflex_cond_e;

    // ----------------------------------------
    // Serial master states
    // ----------------------------------------
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_SETUP = 2'b01,
        SER_SHIFT = 2'b10,
        SER_HOLD = 2'b11
    } serial_state_e;

    // ----------------------------------------
    // Edge conditioning of one reflex line
    // ----------------------------------------
    function automatic logic reflex_condition(input reflex_cond_e mode, input logic prev, input logic cur);
        logic res;
        res = 1'b0;
        unique case (mode)
            COND_LEVEL: res = cur;
            COND_RISE: res = cur & ~prev;
            COND_FALL: res = ~cur & prev;
            COND_BOTH: res = cur ^ prev;
        endcase
        return res;
    endfunction

endpackage

// file: rtl/serial_if.sv
`timescale 1ns/100ps

interface serial_if;
    logic start;
    logic last;
    logic [7:0] tx_byte;
    logic ready;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic sclk;
    logic mosi;
    logic miso;
    logic sel_n;

    modport master (
        input start,
        input last,
        input tx_byte,
        input miso,
        output ready,
        output rx_valid,
        output rx_byte,
        output sclk,
        output mosi,
        output sel_n
    );

    modport user (
        output start,
        output last,
        output tx_byte,
        output miso,
        input ready,
        input rx_valid,
        input rx_byte,
        input sclk,
        input mosi,
        input sel_n
    );
endinterface

// file: rtl/radio_serial_master.sv
`timescale 1ns/100ps
`include "radio_host_link_defines.svh"

module radio_serial_master
    import radio_host_link_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Port side
    serial_if.master sp
);

    serial_state_e state_q, state_d;
    logic [3:0] div_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic last_q;
    logic sclk_q;
    logic sel_n_q;
    logic valid_q;
    logic [7:0] rx_q;

    wire logic div_done = (div_q == `SCLK_HALF_CYC - 4'h1);
    wire logic guard_done = (div_q == `SEL_GUARD_CYC - 4'h1);
    wire logic div_wrap = (state_q == SER_HOLD) ? guard_done : div_done;
    wire logic fall_now = (state_q == SER_SHIFT) & div_done & sclk_q;
    wire logic byte_done = fall_now & (bit_q == `SERIAL_BITS - 4'h1);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SER_IDLE: if (sp.start) state_d = SER_SETUP;
            SER_SETUP: if (div_done) state_d = SER_SHIFT;
            SER_SHIFT: if (byte_done) state_d = last_q ? SER_HOLD : SER_IDLE;
            SER_HOLD: if (guard_done) state_d = SER_IDLE;
        endcase
    end

    // ----------------------------------------
    // Shift engine
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= SER_IDLE;
            div_q <= 4'h0;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            last_q <= 1'b0;
            sclk_q <= 1'b0;
            sel_n_q <= 1'b1;
            valid_q <= 1'b0;
            rx_q <= 8'h00;
        end else begin
            state_q <= state_d;
            valid_q <= byte_done;
            div_q <= (state_q == SER_IDLE || div_wrap) ? 4'h0 : div_q + 4'h1;
            if (state_q == SER_IDLE && sp.start) begin
                shift_q <= sp.tx_byte;
                last_q <= sp.last;
                bit_q <= 4'h0;
                sel_n_q <= 1'b0;
            end
            if (state_q == SER_SHIFT && div_done) begin
                sclk_q <= ~sclk_q;
            end
            if (fall_now) begin
                shift_q <= {shift_q[6:0], sp.miso};
                bit_q <= bit_q + 4'h1;
            end
            if (byte_done) begin
                rx_q <= {shift_q[6:0], sp.miso};
            end
            if (state_q == SER_HOLD && guard_done) begin
                sel_n_q <= 1'b1;
            end
        end
    end

    assign sp.ready = (state_q == SER_IDLE);
    assign sp.rx_valid = valid_q;
    assign sp.rx_byte = rx_q;
    assign sp.sclk = sclk_q;
    assign sp.mosi = shift_q[7];
    assign sp.sel_n = sel_n_q;

endmodule // radio_serial_master

// file: rtl/radio_host_link.sv
// Behaviour
// - Radio reached by serial, reflex, interrupt.
// - Radio interrupt pin is input with interrupt.
// - Lines c and d go straight out.
// - Lines a and b enter reflex network.
// - Routed lines toggle at most about 10 MHz.
// - Lines a and b routable to either pair.
// - Reflex input sensing on after reset, settable.
// - Sixteen clock-sampled falling-edge pin interrupts available.
// - Sampled pin values feed the reflex network.
// - Owning peripheral overrides general pin output.
// - Reflex passes signals with edge conditioning.
`timescale 1ns/100ps
`include "radio_host_link_defines.svh"

module radio_host_link
    import radio_host_link_pkg::*;
(
    // Clocks and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic radio_clk_i,
    // Serial command side
    input wire logic xfer_start_i,
    input wire logic xfer_last_i,
    input wire logic [7:0] xfer_data_i,
    output logic xfer_ready_o,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    // Pin ownership and shutdown control
    input wire logic serial_port_enable_i,
    input wire logic [1:0] pin_gpio_out_i,
    input wire logic shutdown_i,
    // Radio serial pins
    output logic serial_port_clk_o,
    output logic serial_port_tx_o,
    input wire logic serial_port_rx_i,
    output logic radio_select_n_o,
    output logic radio_shutdown_o,
    // Interrupt pins
    input wire logic radio_irq_n_i,
    input wire logic [15:0] pin_i,
    input wire logic [15:0] irq_enable_i,
    input wire logic [15:0] irq_clear_i,
    output logic [15:0] irq_flag_o,
    // Reflex sensing and routing
    input wire logic sense_write_i,
    input wire logic sense_value_i,
    output logic reflex_input_sense_o,
    output logic [15:0] reflex_pin_o,
    input wire logic [3:0] reflex_cond_i,
    input wire logic [1:0] route_enable_i,
    input wire logic route_loc_i,
    output logic [1:0] reflex_out_o,
    output logic [1:0] route_first_o,
    output logic [1:0] route_first_oe_o,
    output logic [1:0] route_second_o,
    output logic [1:0] route_second_oe_o,
    // Radio general lines
    input wire logic radio_gp_line_a_i,
    input wire logic radio_gp_line_b_i,
    input wire logic radio_gp_line_c_i,
    input wire logic radio_gp_line_d_i,
    output logic pad_gp_c_o,
    output logic pad_gp_d_o
);

    // ----------------------------------------
    // Serial master
    // ----------------------------------------
    serial_if sp ();

    logic [1:0] miso_sync_q;

    assign sp.start = xfer_start_i;
    assign sp.last = xfer_last_i;
    assign sp.tx_byte = xfer_data_i;
    assign sp.miso = miso_sync_q[1];

    radio_serial_master u_master (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .sp(sp.master)
    );

    wire logic sclk_pin_d = serial_port_enable_i ? sp.sclk : pin_gpio_out_i[0];
    wire logic tx_pin_d = serial_port_enable_i ? sp.mosi : pin_gpio_out_i[1];

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            miso_sync_q <= 2'b00;
            serial_port_clk_o <= 1'b0;
            serial_port_tx_o <= 1'b0;
            radio_select_n_o <= 1'b1;
            radio_shutdown_o <= 1'b1;
        end else begin
            miso_sync_q <= {miso_sync_q[0], serial_port_rx_i};
            serial_port_clk_o <= sclk_pin_d;
            serial_port_tx_o <= tx_pin_d;
            radio_select_n_o <= sp.sel_n;
            radio_shutdown_o <= shutdown_i;
        end
    end

    // ----------------------------------------
    // Command side outputs
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            xfer_ready_o <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_data_o <= 8'h00;
        end else begin
            xfer_ready_o <= sp.ready & ~xfer_start_i;
            rx_valid_o <= sp.rx_valid;
            rx_data_o <= sp.rx_byte;
        end
    end

    // ----------------------------------------
    // Pin sampling and interrupts
    // ----------------------------------------
    logic [15:0] pin_s1_q;
    logic [15:0] pin_s2_q;
    logic [15:0] pin_prev_q;
    logic sense_q;

    wire logic [15:0] pin_raw = pin_i;
    wire logic [15:0] pin_merged = {pin_raw[15:`RADIO_IRQ_PIN + 1], radio_irq_n_i, pin_raw[`RADIO_IRQ_PIN - 1:0]};
    wire logic [15:0] pin_fall = pin_prev_q & ~pin_s2_q;
    wire logic [15:0] irq_event = pin_fall & irq_enable_i;
    wire logic sense_d = sense_write_i ? sense_value_i : sense_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_s1_q <= 16'h0000;
            pin_s2_q <= 16'h0000;
            pin_prev_q <= 16'h0000;
            irq_flag_o <= 16'h0000;
            reflex_pin_o <= 16'h0000;
        end else begin
            pin_s1_q <= pin_merged;
            pin_s2_q <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
            irq_flag_o <= (irq_flag_o & ~irq_clear_i) | irq_event;
            reflex_pin_o <= sense_q ? pin_s2_q : 16'h0000;
        end
    end

    // ----------------------------------------
    // Reflex input sensing
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sense_q <= `SENSE_RESET;
            reflex_input_sense_o <= `SENSE_RESET;
        end else begin
            sense_q <= sense_d;
            reflex_input_sense_o <= sense_d;
        end
    end

    // ----------------------------------------
    // Radio line capture on radio clock
    // ----------------------------------------
    logic [1:0] gp_l1_q;
    logic [1:0] gp_l2_q;
    logic [1:0] gp_link_q;

    always_ff @(posedge radio_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gp_l1_q <= 2'b00;
            gp_l2_q <= 2'b00;
            gp_link_q <= 2'b00;
        end else begin
            gp_l1_q <= {radio_gp_line_b_i, radio_gp_line_a_i};
            gp_l2_q <= gp_l1_q;
            gp_link_q <= gp_l2_q;
        end
    end

    // ----------------------------------------
    // Crossing and conditioning
    // ----------------------------------------
    logic [1:0] gp_c1_q;
    logic [1:0] gp_c2_q;
    logic [1:0] gp_prev_q;

    wire reflex_cond_e cond_a = reflex_cond_e'(reflex_cond_i[1:0]);
    wire reflex_cond_e cond_b = reflex_cond_e'(reflex_cond_i[3:2]);
    wire logic [1:0] gp_sensed = sense_q ? gp_c2_q : 2'b00;
    wire logic [1:0] gp_prev_sensed = sense_q ? gp_prev_q : 2'b00;
    wire logic [1:0] reflex_d = {reflex_condition(cond_b, gp_prev_sensed[1], gp_sensed[1]),
                                 reflex_condition(cond_a, gp_prev_sensed[0], gp_sensed[0])};
    wire logic [1:0] routed = reflex_d & route_enable_i;
    wire logic use_first = (route_loc_i == `LOC_FIRST);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            gp_c1_q <= 2'b00;
            gp_c2_q <= 2'b00;
            gp_prev_q <= 2'b00;
            reflex_out_o <= 2'b00;
            route_first_o <= 2'b00;
            route_first_oe_o <= 2'b00;
            route_second_o <= 2'b00;
            route_second_oe_o <= 2'b00;
        end else begin
            gp_c1_q <= gp_link_q;
            gp_c2_q <= gp_c1_q;
            gp_prev_q <= gp_c2_q;
            reflex_out_o <= reflex_d;
            route_first_o <= use_first ? routed : 2'b00;
            route_first_oe_o <= use_first ? route_enable_i : 2'b00;
            route_second_o <= use_first ? 2'b00 : routed;
            route_second_oe_o <= use_first ? 2'b00 : route_enable_i;
        end
    end

    // ----------------------------------------
    // Lines c and d straight to pads
    // ----------------------------------------
    assign pad_gp_c_o = radio_gp_line_c_i;
    assign pad_gp_d_o = radio_gp_line_d_i;

endmodule // radio_host_link

// file: sim/radio_host_link_sva.sv
`timescale 1ns/100ps
module radio_host_link_sva (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Watched ports
    input wire logic xfer_start_i,
    input wire logic xfer_ready_o,
    input wire logic rx_valid_o,
    input wire logic serial_port_enable_i,
    input wire logic [1:0] pin_gpio_out_i,
    input wire logic serial_port_clk_o,
    input wire logic serial_port_tx_o,
    input wire logic radio_select_n_o,
    input wire logic [15:0] irq_clear_i,
    input wire logic [15:0] irq_flag_o,
    input wire logic sense_write_i,
    input wire logic sense_value_i,
    input wire logic reflex_input_sense_o,
    input wire logic [15:0] reflex_pin_o,
    input wire logic [1:0] route_enable_i,
    input wire logic route_loc_i,
    input wire logic [1:0] route_first_oe_o,
    input wire logic [1:0] route_second_oe_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    a_ready_drops: assert property (xfer_start_i && xfer_ready_o |=> !xfer_ready_o)
        else $error("ready held after accepted start");
    a_byte_bounded: assert property (xfer_start_i && xfer_ready_o |-> ##[60:80] rx_valid_o)
        else $error("byte not received in time");
    a_select_busy: assert property (rx_valid_o |-> !radio_select_n_o)
        else $error("select high during byte");
    a_pin_override: assert property (!serial_port_enable_i && !$past(serial_port_enable_i)
        && $stable(pin_gpio_out_i) |-> {serial_port_tx_o, serial_port_clk_o} == pin_gpio_out_i)
        else $error("pin not from general output");
    a_flag_sticky: assert property (($past(irq_flag_o) & ~$past(irq_clear_i) & ~irq_flag_o) == 16'h0000)
        else $error("flag lost without clear");
    a_sense_write: assert property (sense_write_i |=> reflex_input_sense_o == $past(sense_value_i))
        else $error("sense write not taken");
    a_sense_gates: assert property (!reflex_input_sense_o && !$past(reflex_input_sense_o)
        && !$past(reflex_input_sense_o, 2) |-> reflex_pin_o == 16'h0000)
        else $error("pin values pass while sense off");
    a_route_pair: assert property ($stable(route_loc_i) && route_loc_i == $past(route_loc_i, 2)
        && $stable(route_enable_i) && route_enable_i == $past(route_enable_i, 2)
        |-> route_first_oe_o == (route_loc_i ? 2'h0 : route_enable_i)
        && route_second_oe_o == (route_loc_i ? route_enable_i : 2'h0))
        else $error("route enables wrong");
endmodule // radio_host_link_sva
bind radio_host_link radio_host_link_sva i_radio_host_link_sva (.*);

// file: sim/radio_slave_model.sv
`timescale 1ns/100ps
module radio_slave_model (
    // Serial pins
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic sel_n_i,
    output logic miso_o
);
    logic [7:0] reply_q[$];
    logic [7:0] got_q[$];
    logic [7:0] out_sr = 8'h00;
    logic [7:0] in_sr = 8'h00;
    int cnt = 0;
    initial miso_o = 1'b0;
    // Reply loaded at select and at each byte boundary
    always @(negedge sel_n_i) begin
        out_sr = reply_q.size() > 0 ? reply_q.pop_front() : 8'h00;
        miso_o = out_sr[7];
    end
    always @(negedge sclk_i) begin
        if (!sel_n_i) begin
            out_sr = (cnt == 0 && reply_q.size() > 0) ? reply_q.pop_front() : out_sr << 1;
            miso_o = out_sr[7];
        end
    end
    always @(posedge sclk_i) begin
        if (!sel_n_i) begin
            in_sr = {in_sr[6:0], mosi_i};
            cnt = (cnt + 1) % 8;
            if (cnt == 0) got_q.push_back(in_sr);
        end
    end
    // Released line shows the inverse of its last bit
    always @(posedge sel_n_i) miso_o = ~miso_o;
endmodule // radio_slave_model

// file: sim/radio_host_link_tb.sv
`timescale 1ns/100ps
module radio_host_link_tb;
    logic clk_i = 1'b0, radio_clk_i = 1'b0, reset_n_i = 1'b0, xfer_start_i = 1'b0, xfer_last_i = 1'b0;
    logic serial_port_enable_i = 1'b1, shutdown_i = 1'b1, sense_write_i = 1'b0, sense_value_i = 1'b1;
    logic route_loc_i = 1'b0, radio_irq_n_i = 1'b1, radio_gp_line_a_i = 1'b0, radio_gp_line_b_i = 1'b0;
    logic radio_gp_line_c_i = 1'b0, radio_gp_line_d_i = 1'b0, serial_port_rx_i, xfer_ready_o, rx_valid_o;
    logic serial_port_clk_o, serial_port_tx_o, radio_select_n_o, radio_shutdown_o, reflex_input_sense_o;
    logic pad_gp_c_o, pad_gp_d_o;
    logic [1:0] pin_gpio_out_i = 2'h0, route_enable_i = 2'h0, reflex_out_o, route_first_o, route_first_oe_o;
    logic [1:0] route_second_o, route_second_oe_o;
    logic [3:0] reflex_cond_i = 4'h0;
    logic [7:0] xfer_data_i = 8'h00, rx_data_o, sent_q[$], reply[3];
    logic [15:0] pin_i = 16'hFFFF, irq_enable_i = 16'h0000, irq_clear_i = 16'h0000, irq_flag_o, reflex_pin_o, want;
    int n_errors = 0, n_checks = 0, seed = 91382, ha, hb, hr;
    always #20 clk_i = ~clk_i;
    initial begin
        #3.3;
        forever #7.5 radio_clk_i = ~radio_clk_i;
    end
    radio_host_link i_radio_host_link (.*);
    radio_slave_model i_radio_slave_model (
        .sclk_i(serial_port_clk_o),
        .mosi_i(serial_port_tx_o),
        .sel_n_i(radio_select_n_o),
        .miso_o(serial_port_rx_i)
    );
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp_v);
        n_checks++;
        if (got !== exp_v) begin
            n_errors++;
            $display("ERROR %0t: got %h want %h", $time, got, exp_v);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Byte transfer, start held a second cycle with other data
    task automatic xfer(input logic [7:0] tx, input logic [7:0] rx, input logic last);
        for (int i = 0; i < 200 && xfer_ready_o !== 1'b1; i++) cycles(1);
        cmp_word(16'(xfer_ready_o), 16'h0001);
        sent_q.push_back(tx);
        xfer_start_i = 1'b1;
        xfer_last_i = last;
        xfer_data_i = tx;
        cycles(1);
        xfer_data_i = ~tx;
        cycles(1);
        xfer_start_i = 1'b0;
        for (int i = 0; i < 200 && rx_valid_o !== 1'b1; i++) cycles(1);
        cmp_word(16'(rx_valid_o), 16'h0001);
        cmp_word(16'(rx_data_o), 16'(rx));
    endtask
    task automatic set_sense(input logic v);
        sense_write_i = 1'b1;
        sense_value_i = v;
        cycles(1);
        sense_write_i = 1'b0;
        cycles(4);
        cmp_word(16'(reflex_input_sense_o), 16'(v));
    endtask
    initial begin
        cycles(3);
        reset_n_i = 1'b1;
        cmp_word({13'h0000, radio_select_n_o, radio_shutdown_o, reflex_input_sense_o}, 16'h0007);
        for (int k = 0; k < 3; k++) begin
            reply[k] = 8'($random(seed));
            i_radio_slave_model.reply_q.push_back(reply[k]);
        end
        for (int k = 0; k < 3; k++) xfer(8'($random(seed)), reply[k], k == 2);
        cycles(12);
        cmp_word(16'(radio_select_n_o), 16'h0001);
        for (int k = 0; k < 3; k++) cmp_word(16'(i_radio_slave_model.got_q[k]), 16'(sent_q[k]));
        serial_port_enable_i = 1'b0;
        for (int k = 0; k < 4; k++) begin
            pin_gpio_out_i = 2'(k);
            shutdown_i = k[0];
            want = 16'(k);
            want[2] = k[0];
            cycles(2);
            cmp_word({13'h0000, radio_shutdown_o, serial_port_tx_o, serial_port_clk_o}, want);
        end
        serial_port_enable_i = 1'b1;
        irq_enable_i = 16'($random(seed)) | 16'h2000;
        cycles(4);
        pin_i = 16'($random(seed));
        radio_irq_n_i = 1'b0;
        want = irq_enable_i & ~pin_i;
        want[13] = 1'b1;
        cycles(6);
        cmp_word(irq_flag_o, want);
        cmp_word(reflex_pin_o, {pin_i[15:14], 1'b0, pin_i[12:0]});
        irq_clear_i = 16'hFFFF;
        cycles(1);
        irq_clear_i = 16'h0000;
        cycles(2);
        cmp_word(irq_flag_o, 16'h0000);
        set_sense(1'b0);
        cmp_word(reflex_pin_o, 16'h0000);
        set_sense(1'b1);
        route_enable_i = 2'h3;
        for (int m = 0; m < 4; m++) begin
            reflex_cond_i = {2'(m), 2'(m)};
            route_loc_i = m[0];
            ha = 0;
            hb = 0;
            hr = 0;
            cycles(10);
            for (int c = 0; c < 50; c++) begin
                radio_gp_line_a_i = c < 20;
                radio_gp_line_b_i = c < 30;
                cycles(1);
                ha += int'(reflex_out_o[0]);
                hb += int'(reflex_out_o[1]);
                hr += int'((m[0] ? route_second_o : route_first_o) === reflex_out_o
                           && (m[0] ? route_first_o : route_second_o) === 2'h0);
                if (c == 15) cmp_word({12'h000, route_first_oe_o, route_second_oe_o}, m[0] ? 16'h0003 : 16'h000C);
                if (c == 15) cmp_word(16'(m[0] ? route_second_o : route_first_o), 16'(m == 0 ? 3 : 0));
            end
            cmp_word(16'(m == 0 ? ha > 15 && hb > 25 : ha == 1 + int'(m == 3) && hb == ha), 16'h0001);
            cmp_word(16'(hr), 16'h0032);
        end
        for (int k = 0; k < 4; k++) begin
            {radio_gp_line_c_i, radio_gp_line_d_i} = 2'($random(seed));
            cycles(1);
            cmp_word({14'h0000, pad_gp_c_o, pad_gp_d_o}, {14'h0000, radio_gp_line_c_i, radio_gp_line_d_i});
        end
        complete_run();
    end
    initial begin
        #200000;
        n_errors++;
        $display("ERROR %0t: run did not finish", $time);
        complete_run();
    end
endmodule // radio_host_link_tb
